// ### common/ext_int_cfg.svh
// Constants for the external interruption identification block.
// Assumes inclusion by bare name from the package and design files.
`ifndef EXT_INT_CFG_SVH
`define EXT_INT_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DAR_W        16
`define CODE_W       12
`define NORM_W       11
`define CE_N         4
`define IO_CONTROL_ELEMENT_N       3
`define AXI_AW       8

// ----------------------------------------------------------------
// Register offsets (byte addresses) and reset values
// ----------------------------------------------------------------
`define OFF_DAR      8'h00
`define OFF_MASK     8'h04
`define OFF_CTRL     8'h08
`define OFF_CODE     8'h0c
`define OFF_STAT     8'h10
`define EXCEPTION_MASK_REGISTER_RESET   16'hffff
`define CTRL_RESET   32'h0000_0000
`define CTRL_WMASK   32'h007f_7f80
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

// ----------------------------------------------------------------
// Exception source register layout
// ----------------------------------------------------------------
`define DAR_RSVD     16'h0003
`define IOCE0_LO     2
`define IOCE1_LO     4
`define IOCE0_MASK   0
`define IOCE1_MASK   2
`define CE_ELC_LO    6

// ----------------------------------------------------------------
// Interruption code layout (index 0 is status word bit 20)
// ----------------------------------------------------------------
`define CODE_WRITE_LO 4
`define CODE_KEY     8
`define CODE_TIMER   9
`define CODE_PIR     10
`define CODE_DAR     11
`define CODE_SHIFT   20
`define STAT_REQ     16

`endif

// ### common/ext_int_pkg.sv
// Types shared by the external interruption identification block.
// Assumes the constants header sits in the include path.
`include "ext_int_cfg.svh"

package ext_int_pkg;

  // ----------------------------------------------------------------
  // Processor state and control register layout
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STATE_ZERO, STATE_ONE, STATE_TWO, STATE_THREE
  } ce_state_e;

  typedef struct packed {
    logic [8:0]          spareHi;
    logic [`CE_N-1:0]    sconAccept;
    logic                testSwitch;
    ce_state_e           ceState;
    logic                spareMid;
    logic [`IO_CONTROL_ELEMENT_N-1:0]  ioceListen;
    logic [`CE_N-1:0]    ceListen;
    logic                extMask;
    logic [6:0]          spareLo;
  } ctrl_s;

  // Normal (program) interruption sources, one-cycle pulses
  typedef struct packed {
    logic [`IO_CONTROL_ELEMENT_N-1:0]  pirReq;
    logic                timerTick;
    logic                interruptKey;
    logic [`CE_N-1:0]    directWrite;
    logic [`CE_N-1:0]    directRead;
  } norm_req_s;

endpackage

// ### core/exception_capture.sv
// Exception source register with read-clear and pulse/level sources.
// Assumes readClear is a one-cycle pulse from the register slave.
`timescale 1ns/1ps
`include "ext_int_cfg.svh"

module exception_capture
  import ext_int_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [`DAR_W-1:0] srcPulse,
  input  wire logic [`DAR_W-1:0] srcLevel,
  input  wire logic              readClear,
  output logic      [`DAR_W-1:0] exception_source_register
);

  // ----------------------------------------------------------------
  // Per-bit capture
  // ----------------------------------------------------------------
  logic [`DAR_W-1:0] dar_reg;
  logic [`DAR_W-1:0] dar_next;
  logic [`DAR_W-1:0] hold_reg;
  logic [`DAR_W-1:0] hold_next;
  // Reserved positions never latch; a literal cannot be bit-selected
  wire  [`DAR_W-1:0] rsvdBits = `DAR_RSVD;

  genvar i;
  generate
    for (i = 0; i < `DAR_W; i++) begin : g_bit
      // Read wipes the bit; level sources re-set it the cycle after
      assign dar_next[i] = readClear ? 1'b0 :
          (dar_reg[i] | hold_reg[i] | srcPulse[i] | srcLevel[i])
          & ~rsvdBits[i];
      // Pulses during a read would be lost, so park them a cycle
      assign hold_next[i] = readClear & srcPulse[i];
    end
  endgenerate

  // Register update, cleared on reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dar_reg  <= '0;
      hold_reg <= '0;
    end else begin
      dar_reg  <= dar_next;
      hold_reg <= hold_next;
    end
  end

  assign exception_source_register = dar_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_readWipes;
    @(posedge clock) disable iff (!reset_n)
      readClear |=> (exception_source_register == '0);
  endproperty
  a_readWipes: assert property (p_readWipes)
    else $error("exception register not cleared by read");

  property p_pulseKept;
    @(posedge clock) disable iff (!reset_n)
      readClear ##1 reset_n |=> ((exception_source_register & $past(srcPulse, 2)) ==
                                 ($past(srcPulse, 2) & ~`DAR_RSVD));
  endproperty
  a_pulseKept: assert property (p_pulseKept)
    else $error("pulse during read was lost");

  property p_bitSticks;
    @(posedge clock) disable iff (!reset_n)
      !readClear |=> ((exception_source_register & $past(exception_source_register)) == $past(exception_source_register));
  endproperty
  a_bitSticks: assert property (p_bitSticks)
    else $error("exception bit dropped without a read");

  property p_levelReturns;
    @(posedge clock) disable iff (!reset_n)
      readClear ##1 (srcLevel != '0) |=>
        ((exception_source_register & $past(srcLevel)) == ($past(srcLevel) & ~`DAR_RSVD));
  endproperty
  a_levelReturns: assert property (p_levelReturns)
    else $error("level source did not re-set its bit");

  c_pulseDuringRead: cover property (@(posedge clock)
      readClear && (srcPulse & ~`DAR_RSVD) != '0);

endmodule

// ### core/external_interrupt_identification.sv
// External interruption identification and masking for one processor.
// Assumes an AXI4-Lite master, one clock, synchronous peer inputs.
//
// What this block does
// - Source identity goes to status bits 20-31
// - Peer direct requests gated by configuration listen bits
// - Listened peer request sets bit, interrupts if bit7
// - Key and timer bits set regardless of configuration
// - Bit 30 flags gated processor-port register sources
// - Element exception request sets its source bit
// - Exception register read only by diagnose access
// - Source, mask, bit7 give interrupt with flag
// - Peer element check forced in states two-zero, in zero only with test switch off
// - Source bits stay until read, then cleared
// - Pulse bits stay clear until next pulse
// - Level bits re-set right after read-clear
// - Read returns register regardless of mask
// - No setting while the read is in progress
// - Mask written only by diagnose write
// - Mask one passes source bit, zero blocks
// - One mask bit covers both I/O code bits
// - Mask positions 1, 3, 4, 5 are spare
// - I/O code: none, battery, temperature, check
// - Flag is bit 31, only for abnormal
// - Masked requests pend, repeats collapse to one
`timescale 1ns/1ps
`include "ext_int_cfg.svh"

module external_interrupt_identification
  import ext_int_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                reset_n,
  // AXI4-Lite slave
  input  wire logic [`AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Program interruption sources
  input  wire norm_req_s           normReq,
  // Hardware exception sources, per source register bit
  input  wire logic [`DAR_W-1:0]   excPulse,
  input  wire logic [`DAR_W-1:0]   excLevel,
  // Processor handshake
  input  wire logic                instrDone,
  output logic                     extIntReq,
  output logic                     extIntTaken,
  output logic [`CODE_W-1:0]       interruptCode
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Merge written bytes into a word
  function automatic logic [31:0] applyStrobe(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Spread the mask over source bits; I/O code pairs share one bit
  function automatic logic [`DAR_W-1:0] expandMask(
    input logic [`DAR_W-1:0] m
  );
    logic [`DAR_W-1:0] res;
    res = m;
    res[`IOCE0_LO +: 2] = {2{m[`IOCE0_MASK]}};
    res[`IOCE1_LO +: 2] = {2{m[`IOCE1_MASK]}};
    // Positions 1, 3, 4, 5 alone never gate anything
    res = res & ~`DAR_RSVD;
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  ctrl_s                  ctrl_reg;
  ctrl_s                  ctrl_next;
  logic [`DAR_W-1:0]      exception_mask_register_reg;
  logic [`DAR_W-1:0]      exception_mask_register_next;
  logic [`NORM_W-1:0]     pend_reg;
  logic [`NORM_W-1:0]     pend_next;
  logic [`CODE_W-1:0]     code_reg;
  logic                   taken_reg;
  logic [`DAR_W-1:0]      exception_source_register;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic                   awHeld_reg;
  logic                   wHeld_reg;
  logic [`AXI_AW-1:0]     awAddr_reg;
  logic [31:0]            wData_reg;
  logic [3:0]             wStrb_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;

  // Address and data accepted separately, one write at a time
  assign s_axi_awready = !awHeld_reg && !bvalid_reg;
  assign s_axi_wready  = !wHeld_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  wire awTake   = s_axi_awvalid && s_axi_awready;
  wire wTake    = s_axi_wvalid && s_axi_wready;
  wire doWrite  = awHeld_reg && wHeld_reg;
  wire wrMask   = doWrite && (awAddr_reg == `OFF_MASK);
  wire wrCtrl   = doWrite && (awAddr_reg == `OFF_CTRL);
  wire wrOk     = wrMask || wrCtrl;

  // Write register file; only a diagnose write reaches the mask
  assign exception_mask_register_next = wrMask ?
      16'(applyStrobe(32'(exception_mask_register_reg), wData_reg, wStrb_reg)) :
      exception_mask_register_reg;
  assign ctrl_next = wrCtrl ?
      ctrl_s'(applyStrobe(ctrl_reg, wData_reg, wStrb_reg) & `CTRL_WMASK) :
      ctrl_reg;

  // Write handshake state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= '0;
      wStrb_reg  <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else begin
      if (awTake) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Configuration and mask registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_reg <= ctrl_s'(`CTRL_RESET);
      exception_mask_register_reg <= `EXCEPTION_MASK_REGISTER_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      exception_mask_register_reg <= exception_mask_register_next;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  wire arTake  = s_axi_arvalid && s_axi_arready;
  wire rdDar   = s_axi_araddr == `OFF_DAR;
  wire rdMask  = s_axi_araddr == `OFF_MASK;
  wire rdCtrl  = s_axi_araddr == `OFF_CTRL;
  wire rdCode  = s_axi_araddr == `OFF_CODE;
  wire rdStat  = s_axi_araddr == `OFF_STAT;
  wire rdOk    = rdDar || rdMask || rdCtrl || rdCode || rdStat;
  // Only an accepted read at the source register offset clears the source register
  wire darReadClear = arTake && rdDar;

  // Read data mux; source register shown unmasked
  wire [31:0] rdWord =
      rdDar  ? 32'(exception_source_register) :
      rdMask ? 32'(exception_mask_register_reg) :
      rdCtrl ? 32'(ctrl_reg) :
      rdCode ? {code_reg, `CODE_SHIFT'(0)} :
      rdStat ? (32'(pend_reg) | (32'(extIntReq) << `STAT_REQ)) :
      32'h0000_0000;

  // Read response, one cycle after address accepted
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= `RESP_OKAY;
    end else if (arTake) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdWord;
      rresp_reg  <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Exception source register
  // ----------------------------------------------------------------
  // I/O code pairs carry 01 battery/parity, 10 temperature, 11 check
  exception_capture exception_capture_inst (
    .clock     (clock),
    .reset_n   (reset_n),
    .srcPulse  (excPulse),
    .srcLevel  (excLevel),
    .readClear (darReadClear),
    .exception_source_register       (exception_source_register)
  );

  // ----------------------------------------------------------------
  // Normal interruption pending bits
  // ----------------------------------------------------------------
  // Peer and port requests only count when listened to
  wire [`NORM_W-1:0] normSet = {
      |(normReq.pirReq & ctrl_reg.ioceListen),
      normReq.timerTick,
      normReq.interruptKey,
      normReq.directWrite & ctrl_reg.ceListen,
      normReq.directRead & ctrl_reg.ceListen
  };

  // ----------------------------------------------------------------
  // Interruption request and masking
  // ----------------------------------------------------------------
  wire [`DAR_W-1:0] darMasked = exception_source_register & expandMask(exception_mask_register_reg);
  wire [`CE_N-1:0]  ceElc     = exception_source_register[`CE_ELC_LO +: `CE_N];
  // Test switch only matters in state zero; state three is excluded
  wire forceState = (ctrl_reg.ceState == STATE_TWO) ||
                    (ctrl_reg.ceState == STATE_ONE) ||
                    (ctrl_reg.ceState == STATE_ZERO &&
                     !ctrl_reg.testSwitch);
  wire forceInt   = forceState &&
                    |(ceElc & ctrl_reg.sconAccept);
  wire abnormal   = (ctrl_reg.extMask && |darMasked) ||
                    forceInt;
  // Masked requests just wait in the pending bits
  wire normalReq  = ctrl_reg.extMask && |pend_reg;
  assign extIntReq = normalReq || abnormal;
  wire take       = instrDone && extIntReq;

  // Taking clears pending bits; a new set in that cycle still wins
  assign pend_next = (take ? `NORM_W'(0) : pend_reg) | normSet;

  // Pending bits and taken interruption code
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pend_reg  <= '0;
      code_reg  <= '0;
      taken_reg <= 1'b0;
    end else begin
      pend_reg  <= pend_next;
      taken_reg <= take;
      if (take) begin
        // Flag bit only for abnormal; normal bits only if unmasked
        code_reg <= {abnormal,
                     ctrl_reg.extMask ? pend_reg : `NORM_W'(0)};
      end
    end
  end

  assign extIntTaken   = taken_reg;
  assign interruptCode = code_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_unlistenedIgnored;
    @(posedge clock) disable iff (!reset_n)
      (normReq.directRead[0] && !ctrl_reg.ceListen[0] && !pend_reg[0])
      |=> !pend_reg[0];
  endproperty
  a_unlistenedIgnored: assert property (p_unlistenedIgnored)
    else $error("unlistened peer request was recorded");

  property p_maskHolds;
    @(posedge clock) disable iff (!reset_n)
      (!ctrl_reg.extMask && !forceInt) |-> !extIntReq;
  endproperty
  a_maskHolds: assert property (p_maskHolds)
    else $error("interruption raised while masked");

  property p_keyPends;
    @(posedge clock) disable iff (!reset_n)
      (normReq.interruptKey && !take) ##1 !take
      |=> pend_reg[`CODE_KEY];
  endproperty
  a_keyPends: assert property (p_keyPends)
    else $error("interrupt key request not held pending");

  property p_flagOnAbnormal;
    @(posedge clock) disable iff (!reset_n)
      take |=> (interruptCode[`CODE_DAR] == $past(abnormal)) &&
               extIntTaken;
  endproperty
  a_flagOnAbnormal: assert property (p_flagOnAbnormal)
    else $error("exception flag wrong in taken code");

  property p_zeroMaskBlocks;
    @(posedge clock) disable iff (!reset_n)
      (exception_mask_register_reg == '0 && pend_reg == '0 && !forceInt) |-> !extIntReq;
  endproperty
  a_zeroMaskBlocks: assert property (p_zeroMaskBlocks)
    else $error("masked exception bit raised a request");

  property p_forceIgnoresMask;
    @(posedge clock) disable iff (!reset_n)
      forceInt |-> extIntReq;
  endproperty
  a_forceIgnoresMask: assert property (p_forceIgnoresMask)
    else $error("forced element check did not interrupt");

  c_normalTaken:   cover property (@(posedge clock) take && !abnormal);
  c_abnormalTaken: cover property (@(posedge clock) take && abnormal);
  c_darRead:       cover property (@(posedge clock) darReadClear);

endmodule

// ### sim/peer_element_model.sv
// Peer elements: exception lines and program requests.
// Assumes the bench raises a pulse command for one clock only.
`timescale 1ns/1ps

module peer_element_model
  import ext_int_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [15:0] pulseCmd,
  input  wire logic [15:0] levelCmd,
  input  wire norm_req_s   normCmd,
  output logic      [15:0] excPulse,
  output logic      [15:0] excLevel,
  output norm_req_s        normReq
);
  // Registered so every line changes just after an edge
  always_ff @(posedge clock) begin
    excPulse <= pulseCmd;
    excLevel <= levelCmd;
    normReq  <= normCmd;
  end
endmodule

// ### sim/external_interrupt_identification_tb_top.sv
// Bench for the external interruption identification block.
// Assumes the peer model and an AXI4-Lite register map at 0x00-0x10.
`timescale 1ns/1ps

module external_interrupt_identification_tb_top
  import ext_int_pkg::*;
;
  logic        clock = 0, reset_n = 0, instrDone = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, r, seed = 30922;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, extIntReq, extIntTaken;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] interruptCode;
  logic [15:0] pulseCmd = 0, levelCmd = 0, excPulse, excLevel;
  norm_req_s   normCmd = '0, normReq;
  logic [33:0] expBus[$];
  logic [11:0] expCode[$];
  int          num_errors = 0, samples_checked = 0;

  always #10 clock = ~clock;

  peer_element_model peer_element_model_inst (.clock, .pulseCmd,
    .levelCmd, .normCmd, .excPulse, .excLevel, .normReq);

  external_interrupt_identification external_interrupt_identification_inst (
    .clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .normReq, .excPulse, .excLevel,
    .instrDone, .extIntReq, .extIntTaken, .interruptCode);

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic cmpBus(input logic [33:0] e, input logic [33:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] bus exp %h got %h", e, s);
    end
  endtask

  task automatic cmpCode(input logic [11:0] e, input logic [11:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] code exp %h got %h", e, s);
    end
  endtask

  // Oldest note is taken off whenever a response or take shows up
  always @(posedge clock) begin
    if (s_axi_rvalid && s_axi_rready)
      cmpBus(expBus.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      cmpBus(expBus.pop_front(), {s_axi_bresp, 32'h0});
    if (extIntTaken)
      cmpCode(expCode.pop_front(), interruptCode);
  end

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Generous span: the sequence needs well under 2000 cycles
  initial begin
    #400000;
    num_errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Each channel is released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rs);
    expBus.push_back({rs, 32'h0});
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
               (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge clock);
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expBus.push_back(e);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask

  task automatic evt(input logic [15:0] p, input logic [12:0] n);
    @(posedge clock);
    pulseCmd <= p;
    normCmd <= norm_req_s'(n);
    @(posedge clock);
    pulseCmd <= '0;
    normCmd <= '0;
  endtask

  // Completion is offered only once a request stands
  task automatic take(input logic [11:0] c);
    expCode.push_back(c);
    do @(posedge clock); while (!extIntReq);
    instrDone <= 1;
    @(posedge clock);
    instrDone <= 0;
    repeat (2) @(posedge clock);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1;
    rd(8'h08, 0);
    rd(8'h04, 34'hffff);
    rd(8'h00, 0);
    rd(8'h10, 0);
    for (int i = 0; i < 3; i++) begin
      r = xs();
      wr(8'h04, r, 0);
      rd(8'h04, {18'h0, r[15:0]});
    end
    wr(8'h00, 1, 2'b10);
    wr(8'h0c, 1, 2'b10);
    rd(8'h20, 34'h200000000);
    wr(8'h04, 32'hffff, 0);
    wr(8'h08, 32'h1180, 0);
    rd(8'h08, 34'h1180);
    evt(0, 13'h1b23);
    take(12'h301);
    evt(0, 13'h0410);
    take(12'h410);
    evt(16'h0400, 0);
    take(12'h800);
    rd(8'h00, 34'h0400);
    rd(8'h00, 0);
    levelCmd <= 16'h1000;
    repeat (3) @(posedge clock);
    rd(8'h00, 34'h1000);
    rd(8'h00, 34'h1000);
    levelCmd <= 0;
    repeat (3) @(posedge clock);
    rd(8'h00, 34'h1000);
    rd(8'h00, 0);
    wr(8'h04, 2, 0);
    levelCmd <= 16'h0008;
    repeat (3) @(posedge clock);
    rd(8'h10, 0);
    rd(8'h00, 34'h0008);
    wr(8'h04, 1, 0);
    rd(8'h10, 34'h10000);
    levelCmd <= 0;
    repeat (3) @(posedge clock);
    rd(8'h00, 34'h0008);
    rd(8'h00, 0);
    wr(8'h08, 32'h80000, 0);
    wr(8'h04, 0, 0);
    evt(16'h0040, 0);
    take(12'h800);
    rd(8'h00, 34'h0040);
    // State zero with test switch on, then state three: no forcing
    wr(8'h08, 32'hc0000, 0);
    evt(16'h0040, 0);
    rd(8'h10, 0);
    wr(8'h08, 32'hb0000, 0);
    rd(8'h10, 0);
    // State two forces the same pending element check
    wr(8'h08, 32'ha0000, 0);
    rd(8'h10, 34'h10000);
    rd(8'h00, 34'h0040);
    wr(8'h08, 0, 0);
    evt(0, 13'h0100);
    evt(0, 13'h0100);
    rd(8'h10, 34'h0100);
    wr(8'h08, 32'h80, 0);
    take(12'h100);
    rd(8'h10, 0);
    // Let the monitor take the last answer before the verdict
    repeat (2) @(posedge clock);
    // A note never matched by a result is a miss too
    if (expBus.size() != 0 || expCode.size() != 0) num_errors++;
    conclude();
  end
endmodule
